// >>> verification/dpbb_bank_checker.sv
`timescale 1ns/1ps
`default_nettype none

module dpbb_bank_checker #(
    parameter int ADDR_W = 16
) (
    input wire logic              CLK,
    input wire logic              SYS_RST,
    input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic              S_AXI_AWVALID,
    input wire logic              S_AXI_AWREADY,
    input wire logic [31:0]       S_AXI_WDATA,
    input wire logic [3:0]        S_AXI_WSTRB,
    input wire logic              S_AXI_WVALID,
    input wire logic              S_AXI_WREADY,
    input wire logic [1:0]        S_AXI_BRESP,
    input wire logic              S_AXI_BVALID,
    input wire logic              S_AXI_BREADY,
    input wire logic              S_AXI_ARVALID,
    input wire logic              S_AXI_ARREADY,
    input wire logic [31:0]       S_AXI_RDATA,
    input wire logic              S_AXI_RVALID,
    input wire logic              S_AXI_RREADY
);
    logic [15:0] idx_r;
    logic [15:0] val_r;
    logic        full_r;
    logic        bv_r;
    logic        done;

    // ========
    // write under way, judged when its response first shows
    always_ff @(posedge CLK) begin
        bv_r <= SYS_RST ? 1'b0 : S_AXI_BVALID;
        if (S_AXI_AWVALID && S_AXI_AWREADY) idx_r <= 16'(S_AXI_AWADDR >> 2);
        if (S_AXI_WVALID && S_AXI_WREADY) begin
            val_r  <= S_AXI_WDATA[15:0];
            full_r <= &S_AXI_WSTRB[1:0];
        end
    end
    assign done = S_AXI_BVALID && !bv_r && full_r;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    // ========
    // refused values
    AST_RSVD_REFUSED: assert property (done && (idx_r inside {16'h1321, 16'h1322,
        [16'h1331:16'h1333]}) |-> S_AXI_BRESP == 2'h2) else $error("reserved write taken");
    AST_LEVEL_RANGE: assert property (done && idx_r inside {16'h1317, 16'h131a, 16'h131d}
        && (val_r < 16'h00c8 || val_r > 16'h07d0) |-> S_AXI_BRESP == 2'h2) else $error("level");
    AST_TIME_RANGE: assert property (done && idx_r inside {16'h1318, 16'h131b, 16'h131e}
        && (val_r < 16'h000a || val_r > 16'h0bb8) |-> S_AXI_BRESP == 2'h2) else $error("time");
    AST_MODE_CODES: assert property (done && idx_r inside {16'h1316, 16'h1319}
        && val_r > 16'h0003 |-> S_AXI_BRESP == 2'h2) else $error("overload mode code");
    AST_SEL3_CODES: assert property (done && idx_r inside {16'h131f, 16'h1325}
        && val_r > 16'h0002 |-> S_AXI_BRESP == 2'h2) else $error("three way code");
    AST_SEL5_CODES: assert property (done && idx_r inside {16'h132a, 16'h1327}
        && val_r > 16'h0004 |-> S_AXI_BRESP == 2'h2) else $error("five way code");
    AST_TORQUE_RANGE: assert property (done && idx_r inside {[16'h132b:16'h132e]}
        && val_r > 16'h00c8 && val_r != 16'h00ff |-> S_AXI_BRESP == 2'h2) else $error("torque");
    AST_SOFT_RANGE: assert property (done && idx_r == 16'h1326 && val_r > 16'h00ff
        |-> S_AXI_BRESP == 2'h2) else $error("soft start");
    AST_REV_FLAG: assert property (done && idx_r == 16'h1330 && val_r > 16'h0001
        |-> S_AXI_BRESP == 2'h2) else $error("reverse prevention");

    // ========
    // bus answers
    AST_WR_ANSWER: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
        && S_AXI_WREADY |-> ##[1:3] S_AXI_BVALID) else $error("write not answered");
    AST_B_STANDS: assert property (S_AXI_BVALID && !S_AXI_BREADY
        |=> S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write response dropped");
    AST_R_ANSWER: assert property (S_AXI_ARVALID && S_AXI_ARREADY
        |=> S_AXI_RVALID && S_AXI_RDATA[31:16] == 16'h0000) else $error("read answer");
    AST_R_STANDS: assert property (S_AXI_RVALID && !S_AXI_RREADY
        |=> S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read data dropped");
endmodule : dpbb_bank_checker

bind dpbb_bank dpbb_bank_checker #(.ADDR_W(ADDR_W)) u_checker (.*);

`default_nettype wire

// >>> verification/dpbb_bank_tb.sv
`timescale 1ns/1ps
`default_nettype none

`include "dpbb_defs.svh"

module dpbb_bank_tb;
    logic        CLK, SYS_RST, SOFT_LOCK_TERMINAL, MOTOR_RUNNING, LARGE_DRIVE_CLASS;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [15:0] awaddr, araddr, v;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic [15:0] shadow [16'h1316:16'h1381];
    int          fail_count = 0;
    int          tests_run = 0;

    // ========
    // address, value, flags (bit0 accepted, bit4 large class)
    localparam logic [47:0] RNG [31] = '{
        48'h1317_00c8_0001, 48'h1317_00c7_0000, 48'h131a_07d0_0001,
        48'h131d_07d1_0000, 48'h1317_0708_0011, 48'h1317_0709_0010,
        48'h1318_000a_0001, 48'h1318_0009_0000, 48'h131e_0bb8_0001,
        48'h131b_0bb9_0000, 48'h1319_0003_0001, 48'h1319_0004_0000,
        48'h1316_0003_0001, 48'h1316_0004_0000, 48'h131f_0003_0000,
        48'h1325_0002_0001, 48'h1326_00ff_0001, 48'h1326_0100_0000,
        48'h132a_0004_0001, 48'h132a_0005_0000, 48'h132d_00ff_0001,
        48'h132c_00c9_0000, 48'h132b_00b5_0010, 48'h1327_0005_0000,
        48'h1330_0001_0001, 48'h1330_0002_0000, 48'h1323_ffff_0001,
        48'h1320_0004_0000, 48'h1328_0006_0000, 48'h131c_0002_0000,
        48'h1333_0001_0000};
    // selector, pins (bit4 soft lock, bit0 running), address, accepted
    localparam logic [39:0] LCK [12] = '{
        40'h00_10_1325_00, 40'h00_10_1380_00, 40'h00_00_1325_01,
        40'h01_10_1325_00, 40'h01_10_1380_01, 40'h01_00_1325_01,
        40'h02_00_1325_00, 40'h02_00_1380_00, 40'h03_00_1380_01,
        40'h03_10_1325_00, 40'h0a_01_1325_01, 40'h00_01_1325_00};

    dpbb_bank DUT (
        .CLK(CLK), .SYS_RST(SYS_RST), .SOFT_LOCK_TERMINAL(SOFT_LOCK_TERMINAL),
        .MOTOR_RUNNING(MOTOR_RUNNING), .LARGE_DRIVE_CLASS(LARGE_DRIVE_CLASS),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

    dpbb_host host (.clk(CLK), .*);

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic rdc(input logic [15:0] idx);
        logic [1:0]  resp;
        logic [15:0] d;
        host.rd(idx, d, resp);
        chk("read data", shadow[idx], d);
        chk("read response", (idx inside {16'h1321, 16'h1322, [16'h1331:16'h1333]})
            ? `DPBB_RESP_SLVERR : `DPBB_RESP_OKAY, 16'(resp));
    endtask : rdc

    task automatic wrc(input logic [15:0] idx, input logic [15:0] val, input logic [3:0] s,
                       input logic ok);
        logic [1:0]  resp;
        logic [15:0] m;
        m = {s[1] ? val[15:8] : shadow[idx][15:8], s[0] ? val[7:0] : shadow[idx][7:0]};
        host.wr(idx, val, s, resp);
        chk("write response", ok ? `DPBB_RESP_OKAY : `DPBB_RESP_SLVERR, 16'(resp));
        if (ok) shadow[idx] = m;
        rdc(idx);
    endtask : wrc

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict

    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end

    initial begin
        repeat (20000) @(posedge CLK);
        fail_count++;
        $display("MISMATCH run length expected finish seen hang");
        print_verdict();
    end

    initial begin
        {SYS_RST, SOFT_LOCK_TERMINAL, MOTOR_RUNNING, LARGE_DRIVE_CLASS} = 4'h8;
        foreach (shadow[i]) shadow[i] = (i inside {16'h1317, 16'h131a, 16'h131d})
            ? `DPBB_DEF_LEVEL : (i inside {16'h1318, 16'h131b, 16'h131e}) ? `DPBB_DEF_TIME
            : (i inside {[16'h132b:16'h132e]}) ? `DPBB_DEF_TRQ : 16'h0000;
        repeat (6) @(posedge CLK);
        SYS_RST <= 1'b0;
        // ========
        // reset values, slow host answers
        host.lag = 2;
        for (int i = 16'h1316; i <= 16'h1333; i++) rdc(16'(i));
        host.lag = 0;
        $display("test reset_values done");
        // ========
        // ranges and codes
        foreach (RNG[i]) begin
            if (LARGE_DRIVE_CLASS !== RNG[i][4]) begin
                LARGE_DRIVE_CLASS <= RNG[i][4];
                repeat (3) @(posedge CLK);
            end
            wrc(RNG[i][47:32], RNG[i][31:16], 4'h3, RNG[i][0]);
        end
        wrc(16'h1324, 16'hab00, 4'h2, 1'b1);
        shadow[16'h1381] = 16'h0002;
        rdc(16'h1381);
        $display("test ranges done");
        // ========
        // write protection
        foreach (LCK[i]) begin
            SOFT_LOCK_TERMINAL <= 1'b0;
            MOTOR_RUNNING      <= 1'b0;
            repeat (3) @(posedge CLK);
            wrc(16'h1320, {8'h00, LCK[i][39:32]}, 4'h3, 1'b1);
            SOFT_LOCK_TERMINAL <= LCK[i][28];
            MOTOR_RUNNING      <= LCK[i][24];
            repeat (3) @(posedge CLK);
            v = (LCK[i][23:8] == 16'h1380) ? shadow[16'h1380] + 16'h0001
                : shadow[16'h1325] % 16'h0002 + 16'h0001;
            wrc(LCK[i][23:8], v, 4'h3, LCK[i][0]);
        end
        $display("test write_protect done");
        print_verdict();
    end
endmodule : dpbb_bank_tb

`default_nettype wire

// >>> verification/dpbb_host.sv
`timescale 1ns/1ps
`default_nettype none

module dpbb_host #(
    parameter int ADDR_W = 16
) (
    input  wire logic              clk,
    output var  logic [ADDR_W-1:0] awaddr,
    output var  logic              awvalid,
    input  wire logic              awready,
    output var  logic [31:0]       wdata,
    output var  logic [3:0]        wstrb,
    output var  logic              wvalid,
    input  wire logic              wready,
    input  wire logic [1:0]        bresp,
    input  wire logic              bvalid,
    output var  logic              bready,
    output var  logic [ADDR_W-1:0] araddr,
    output var  logic              arvalid,
    input  wire logic              arready,
    input  wire logic [31:0]       rdata,
    input  wire logic [1:0]        rresp,
    input  wire logic              rvalid,
    output var  logic              rready
);
    // cycles the host lets an answer wait before taking it
    int lag = 0;

    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata, wstrb} = '0;
    end

    task automatic wr(input logic [15:0] idx, input logic [15:0] d,
                      input logic [3:0] s, output logic [1:0] resp);
        logic aw;
        logic w;
        begin
            aw = 1'b0;
            w  = 1'b0;
            @(posedge clk);
            awaddr  <= ADDR_W'({idx, 2'b00});
            wdata   <= {16'h0000, d};
            wstrb   <= s;
            awvalid <= 1'b1;
            wvalid  <= 1'b1;
            while (!(aw && w)) begin
                @(posedge clk);
                aw = aw || awready;
                w  = w || wready;
                awvalid <= !aw;
                wvalid  <= !w;
            end
            // released lines must not keep looking valid
            awaddr <= ~awaddr;
            wdata  <= ~wdata;
            repeat (lag) @(posedge clk);
            bready <= 1'b1;
            do @(posedge clk); while (!bvalid);
            resp = bresp;
            bready <= 1'b0;
        end
    endtask : wr

    task automatic rd(input logic [15:0] idx, output logic [15:0] d, output logic [1:0] resp);
        begin
            @(posedge clk);
            araddr  <= ADDR_W'({idx, 2'b00});
            arvalid <= 1'b1;
            do @(posedge clk); while (!arready);
            arvalid <= 1'b0;
            araddr  <= ~araddr;
            repeat (lag) @(posedge clk);
            rready <= 1'b1;
            do @(posedge clk); while (!rvalid);
            d    = rdata[15:0];
            resp = rresp;
            rready <= 1'b0;
        end
    endtask : rd
endmodule : dpbb_host

`default_nettype wire

// >>> verilog/dpbb_bank.sv

`timescale 1ns/1ps
`default_nettype none

`include "dpbb_defs.svh"

module dpbb_bank #(
    parameter int ADDR_W = 16
) (
    input  wire logic              CLK,
    input  wire logic              SYS_RST,
    input  wire logic              SOFT_LOCK_TERMINAL,
    input  wire logic              MOTOR_RUNNING,
    input  wire logic              LARGE_DRIVE_CLASS,
    input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
    input  wire logic              S_AXI_AWVALID,
    output var  logic              S_AXI_AWREADY,
    input  wire logic [31:0]       S_AXI_WDATA,
    input  wire logic [3:0]        S_AXI_WSTRB,
    input  wire logic              S_AXI_WVALID,
    output var  logic              S_AXI_WREADY,
    output var  logic [1:0]        S_AXI_BRESP,
    output var  logic              S_AXI_BVALID,
    input  wire logic              S_AXI_BREADY,
    input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
    input  wire logic              S_AXI_ARVALID,
    output var  logic              S_AXI_ARREADY,
    output var  logic [31:0]       S_AXI_RDATA,
    output var  logic [1:0]        S_AXI_RRESP,
    output var  logic              S_AXI_RVALID,
    input  wire logic              S_AXI_RREADY
);

    dpbb_pkg::dpbb_state_t q_r;
    dpbb_pkg::dpbb_state_t q_nxt;
    dpbb_pkg::dpbb_word_t  wr_val;
    dpbb_pkg::dpbb_word_t  rd_idx;
    logic                  wr_mapped;
    logic                  wr_ok;
    logic                  rd_mapped;
    logic                  wr_locked;

    // ==========================================================
    // helpers
    function automatic dpbb_pkg::dpbb_word_t addr_idx(input logic [ADDR_W-1:0] a);
        addr_idx = 16'(a[ADDR_W-1:2]);
    endfunction : addr_idx

    function automatic logic [4:0] slot(input dpbb_pkg::dpbb_word_t idx);
        dpbb_pkg::dpbb_word_t d;
        d    = idx - `DPBB_IDX_FIRST;
        slot = d[4:0];
    endfunction : slot

    function automatic logic in_bank(input dpbb_pkg::dpbb_word_t idx);
        in_bank = (idx >= `DPBB_IDX_FIRST) && (idx <= `DPBB_IDX_REVPREV);
    endfunction : in_bank

    // current word at an index; unmapped and reserved read as zero
    function automatic dpbb_pkg::dpbb_word_t word_at(input dpbb_pkg::dpbb_state_t st,
                                                    input dpbb_pkg::dpbb_word_t  idx);
        word_at = 16'h0000;
        if (idx == `DPBB_IDX_FREQ) begin
            word_at = st.freq;
        end else if (idx == `DPBB_IDX_STAT) begin
            word_at[`DPBB_STAT_LOCK]  = st.lock_err;
            word_at[`DPBB_STAT_RANGE] = st.range_err;
            word_at[`DPBB_STAT_SFT]   = st.sft_sync;
            word_at[`DPBB_STAT_RUN]   = st.run_sync;
            word_at[`DPBB_STAT_LARGE] = st.big_sync;
        end else if (in_bank(idx)) begin
            word_at = st.bank[slot(idx)];
        end
    endfunction : word_at

    // byte-lane merge of the low half word
    function automatic dpbb_pkg::dpbb_word_t merge(input dpbb_pkg::dpbb_word_t old,
                                                  input logic [31:0]           d,
                                                  input logic [3:0]            strb);
        merge[7:0]  = strb[0] ? d[7:0]  : old[7:0];
        merge[15:8] = strb[1] ? d[15:8] : old[15:8];
    endfunction : merge

    // write-protect decision for one index
    function automatic logic locked(input dpbb_pkg::dpbb_word_t wp,
                                    input logic                 soft_lock_terminal,
                                    input logic                 run,
                                    input dpbb_pkg::dpbb_word_t idx);
        logic is_freq;
        is_freq = (idx == `DPBB_IDX_FREQ);
        locked  = 1'b0;
        case (wp)
            `DPBB_WP_SFT_ALL: begin
                locked = soft_lock_terminal;
            end
            `DPBB_WP_SFT_FREQ: begin
                locked = soft_lock_terminal && !is_freq;
            end
            `DPBB_WP_ALL: begin
                locked = 1'b1;
            end
            `DPBB_WP_FREQ: begin
                locked = !is_freq;
            end
            default: begin
                locked = 1'b0;
            end
        endcase
        // running motor freezes the bank unless selector says otherwise
        if (run && (wp != `DPBB_WP_RUN) && !is_freq) begin
            locked = 1'b1;
        end
        if ((idx == `DPBB_IDX_WP) || (idx == `DPBB_IDX_STAT)) begin
            locked = 1'b0;
        end
    endfunction : locked

    function automatic dpbb_pkg::dpbb_state_t reset_state();
        dpbb_pkg::dpbb_state_t r;
        r         = '0;
        r.awready = 1'b1;
        r.wready  = 1'b1;
        r.arready = 1'b1;
        r.bank[slot(`DPBB_IDX_LVL1)]      = `DPBB_DEF_LEVEL;
        r.bank[slot(`DPBB_IDX_LVL2)]      = `DPBB_DEF_LEVEL;
        r.bank[slot(`DPBB_IDX_PULL_LVL)]  = `DPBB_DEF_LEVEL;
        r.bank[slot(`DPBB_IDX_TIME1)]     = `DPBB_DEF_TIME;
        r.bank[slot(`DPBB_IDX_TIME2)]     = `DPBB_DEF_TIME;
        r.bank[slot(`DPBB_IDX_PULL_TIME)] = `DPBB_DEF_TIME;
        r.bank[slot(`DPBB_IDX_TRQ1)]      = `DPBB_DEF_TRQ;
        r.bank[slot(`DPBB_IDX_TRQ2)]      = `DPBB_DEF_TRQ;
        r.bank[slot(`DPBB_IDX_TRQ3)]      = `DPBB_DEF_TRQ;
        r.bank[slot(`DPBB_IDX_TRQ4)]      = `DPBB_DEF_TRQ;
        reset_state = r;
    endfunction : reset_state

    // ==========================================================
    // value checks for the pending write and the read address
    assign wr_val = merge(word_at(q_r, q_r.aw_idx), q_r.w_data, q_r.w_strb);
    assign rd_idx = addr_idx(S_AXI_ARADDR);
    assign wr_locked = locked(q_r.bank[slot(`DPBB_IDX_WP)], q_r.sft_sync,
                              q_r.run_sync, q_r.aw_idx);

    dpbb_range_check u_wr_check (
        .idx    (q_r.aw_idx),
        .value  (wr_val),
        .big    (q_r.big_sync),
        .mapped (wr_mapped),
        .ok     (wr_ok)
    );

    dpbb_range_check u_rd_check (
        .idx    (rd_idx),
        .value  (16'h0000),
        .big    (q_r.big_sync),
        .mapped (rd_mapped),
        .ok     ()
    );

    // ==========================================================
    // next state
    always_comb begin
        q_nxt = q_r;

        // pin synchronisers
        q_nxt.sft_meta = SOFT_LOCK_TERMINAL;
        q_nxt.sft_sync = q_r.sft_meta;
        q_nxt.run_meta = MOTOR_RUNNING;
        q_nxt.run_sync = q_r.run_meta;
        q_nxt.big_meta = LARGE_DRIVE_CLASS;
        q_nxt.big_sync = q_r.big_meta;

        // write address and data captured in either order
        if (q_r.awready && S_AXI_AWVALID) begin
            q_nxt.aw_have = 1'b1;
            q_nxt.aw_idx  = addr_idx(S_AXI_AWADDR);
        end
        if (q_r.wready && S_AXI_WVALID) begin
            q_nxt.w_have = 1'b1;
            q_nxt.w_data = S_AXI_WDATA;
            q_nxt.w_strb = S_AXI_WSTRB;
        end
        if (q_r.bvalid && S_AXI_BREADY) begin
            q_nxt.bvalid = 1'b0;
        end

        // commit once both halves are held
        if (q_r.aw_have && q_r.w_have && !q_r.bvalid) begin
            q_nxt.aw_have = 1'b0;
            q_nxt.w_have  = 1'b0;
            q_nxt.bvalid  = 1'b1;
            q_nxt.bresp   = `DPBB_RESP_SLVERR;
            if (!wr_mapped) begin
                q_nxt.bresp = `DPBB_RESP_SLVERR;
            end else if (wr_locked) begin
                q_nxt.lock_err = 1'b1;
            end else if (!wr_ok) begin
                q_nxt.range_err = 1'b1;
            end else begin
                q_nxt.bresp = `DPBB_RESP_OKAY;
                if (q_r.aw_idx == `DPBB_IDX_STAT) begin
                    // write one to clear
                    if (wr_val[`DPBB_STAT_LOCK]) begin
                        q_nxt.lock_err = 1'b0;
                    end
                    if (wr_val[`DPBB_STAT_RANGE]) begin
                        q_nxt.range_err = 1'b0;
                    end
                end else if (q_r.aw_idx == `DPBB_IDX_FREQ) begin
                    q_nxt.freq = wr_val;
                end else begin
                    q_nxt.bank[slot(q_r.aw_idx)] = wr_val;
                end
            end
        end
        q_nxt.awready = !q_nxt.aw_have && !q_nxt.bvalid;
        q_nxt.wready  = !q_nxt.w_have && !q_nxt.bvalid;

        // read channel
        if (q_r.rvalid && S_AXI_RREADY) begin
            q_nxt.rvalid = 1'b0;
        end
        if (q_r.arready && S_AXI_ARVALID) begin
            q_nxt.rvalid = 1'b1;
            q_nxt.rdata  = {16'h0000, word_at(q_r, rd_idx)};
            q_nxt.rresp  = rd_mapped ? `DPBB_RESP_OKAY : `DPBB_RESP_SLVERR;
        end
        q_nxt.arready = !q_nxt.rvalid;
    end

    // ==========================================================
    // state register
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            q_r <= reset_state();
        end else begin
            q_r <= q_nxt;
        end
    end

    // ==========================================================
    // outputs
    assign S_AXI_AWREADY = q_r.awready;
    assign S_AXI_WREADY  = q_r.wready;
    assign S_AXI_BVALID  = q_r.bvalid;
    assign S_AXI_BRESP   = q_r.bresp;
    assign S_AXI_ARREADY = q_r.arready;
    assign S_AXI_RVALID  = q_r.rvalid;
    assign S_AXI_RDATA   = q_r.rdata;
    assign S_AXI_RRESP   = q_r.rresp;

endmodule : dpbb_bank

`default_nettype wire

// >>> verilog/dpbb_defs.svh
`ifndef DPBB_DEFS_SVH
`define DPBB_DEFS_SVH

// ==========================================================
// register indices (byte address = index * 4)
`define DPBB_IDX_FIRST     16'h1316
`define DPBB_NREG          27
`define DPBB_IDX_OLM1      16'h1316
`define DPBB_IDX_LVL1      16'h1317
`define DPBB_IDX_TIME1     16'h1318
`define DPBB_IDX_OLM2      16'h1319
`define DPBB_IDX_LVL2      16'h131a
`define DPBB_IDX_TIME2     16'h131b
`define DPBB_IDX_OCS       16'h131c
`define DPBB_IDX_PULL_LVL  16'h131d
`define DPBB_IDX_PULL_TIME 16'h131e
`define DPBB_IDX_PULL_FREQ 16'h131f
`define DPBB_IDX_WP        16'h1320
`define DPBB_IDX_RSV_A     16'h1321
`define DPBB_IDX_RSV_B     16'h1322
`define DPBB_IDX_HRS_H     16'h1323
`define DPBB_IDX_HRS_L     16'h1324
`define DPBB_IDX_DIR       16'h1325
`define DPBB_IDX_SOFT      16'h1326
`define DPBB_IDX_DISP      16'h1327
`define DPBB_IDX_SCREEN    16'h1328
`define DPBB_IDX_AUTOSAVE  16'h1329
`define DPBB_IDX_TSRC      16'h132a
`define DPBB_IDX_TRQ1      16'h132b
`define DPBB_IDX_TRQ2      16'h132c
`define DPBB_IDX_TRQ3      16'h132d
`define DPBB_IDX_TRQ4      16'h132e
`define DPBB_IDX_RAMPHOLD  16'h132f
`define DPBB_IDX_REVPREV   16'h1330
`define DPBB_IDX_FREQ      16'h1380
`define DPBB_IDX_STAT      16'h1381

// ==========================================================
// write-protect selector codes
`define DPBB_WP_SFT_ALL    16'h0000
`define DPBB_WP_SFT_FREQ   16'h0001
`define DPBB_WP_ALL        16'h0002
`define DPBB_WP_FREQ       16'h0003
`define DPBB_WP_RUN        16'h000a

// ==========================================================
// value limits
`define DPBB_LVL_MIN       16'h00c8
`define DPBB_LVL_MAX_S     16'h07d0
`define DPBB_LVL_MAX_L     16'h0708
`define DPBB_TIME_MIN      16'h000a
`define DPBB_TIME_MAX      16'h0bb8
`define DPBB_TRQ_MAX_S     16'h00c8
`define DPBB_TRQ_MAX_L     16'h00b4
`define DPBB_TRQ_NONE      16'h00ff
`define DPBB_OLM_MAX       16'h0003
`define DPBB_SEL3_MAX      16'h0002
`define DPBB_SEL5_MAX      16'h0004
`define DPBB_SCREEN_MAX    16'h0005
`define DPBB_FLAG_MAX      16'h0001
`define DPBB_SOFT_MAX      16'h00ff

// ==========================================================
// status bits, responses, reset values
`define DPBB_STAT_LOCK     0
`define DPBB_STAT_RANGE    1
`define DPBB_STAT_SFT      2
`define DPBB_STAT_RUN      3
`define DPBB_STAT_LARGE    4
`define DPBB_RESP_OKAY     2'h0
`define DPBB_RESP_SLVERR   2'h2
`define DPBB_DEF_LEVEL     16'h05dc
`define DPBB_DEF_TIME      16'h0064
`define DPBB_DEF_TRQ       16'h0096

`endif

// >>> verilog/dpbb_pkg.sv
`default_nettype none

`include "dpbb_defs.svh"

package dpbb_pkg;

    typedef logic [15:0] dpbb_word_t;

    typedef struct packed {
        logic                           sft_meta;
        logic                           sft_sync;
        logic                           run_meta;
        logic                           run_sync;
        logic                           big_meta;
        logic                           big_sync;
        dpbb_word_t [`DPBB_NREG-1:0]    bank;
        dpbb_word_t                     freq;
        logic                           lock_err;
        logic                           range_err;
        logic                           aw_have;
        dpbb_word_t                     aw_idx;
        logic                           w_have;
        logic [31:0]                    w_data;
        logic [3:0]                     w_strb;
        logic                           awready;
        logic                           wready;
        logic                           bvalid;
        logic [1:0]                     bresp;
        logic                           arready;
        logic                           rvalid;
        logic [31:0]                    rdata;
        logic [1:0]                     rresp;
    } dpbb_state_t;

endpackage : dpbb_pkg

`default_nettype wire

// >>> verilog/dpbb_range_check.sv
`timescale 1ns/1ps
`default_nettype none

`include "dpbb_defs.svh"

module dpbb_range_check (
    input  wire dpbb_pkg::dpbb_word_t idx,
    input  wire dpbb_pkg::dpbb_word_t value,
    input  wire logic                 big,
    output var  logic                 mapped,
    output var  logic                 ok
);

    // ==========================================================
    // per-register legal values
    always_comb begin
        mapped = 1'b1;
        ok     = 1'b0;
        case (idx)
            `DPBB_IDX_OLM1, `DPBB_IDX_OLM2: begin
                ok = (value <= `DPBB_OLM_MAX);
            end
            `DPBB_IDX_LVL1, `DPBB_IDX_LVL2, `DPBB_IDX_PULL_LVL: begin
                ok = (value >= `DPBB_LVL_MIN) &&
                     (value <= (big ? `DPBB_LVL_MAX_L : `DPBB_LVL_MAX_S));
            end
            `DPBB_IDX_TIME1, `DPBB_IDX_TIME2, `DPBB_IDX_PULL_TIME: begin
                ok = (value >= `DPBB_TIME_MIN) && (value <= `DPBB_TIME_MAX);
            end
            `DPBB_IDX_OCS, `DPBB_IDX_AUTOSAVE, `DPBB_IDX_RAMPHOLD: begin
                ok = (value <= `DPBB_FLAG_MAX);
            end
            `DPBB_IDX_REVPREV: begin
                ok = (value <= `DPBB_FLAG_MAX);
            end
            `DPBB_IDX_PULL_FREQ: begin
                ok = (value <= `DPBB_SEL3_MAX);
            end
            `DPBB_IDX_DIR: begin
                ok = (value <= `DPBB_SEL3_MAX);
            end
            `DPBB_IDX_WP: begin
                ok = (value <= `DPBB_WP_FREQ) || (value == `DPBB_WP_RUN);
            end
            `DPBB_IDX_HRS_H, `DPBB_IDX_HRS_L: begin
                ok = 1'b1;
            end
            `DPBB_IDX_SOFT: begin
                ok = (value <= `DPBB_SOFT_MAX);
            end
            `DPBB_IDX_DISP: begin
                ok = (value <= `DPBB_SEL5_MAX);
            end
            `DPBB_IDX_SCREEN: begin
                ok = (value <= `DPBB_SCREEN_MAX);
            end
            `DPBB_IDX_TSRC: begin
                ok = (value <= `DPBB_SEL5_MAX);
            end
            `DPBB_IDX_TRQ1, `DPBB_IDX_TRQ2, `DPBB_IDX_TRQ3, `DPBB_IDX_TRQ4: begin
                ok = (value <= (big ? `DPBB_TRQ_MAX_L : `DPBB_TRQ_MAX_S)) ||
                     (value == `DPBB_TRQ_NONE);
            end
            `DPBB_IDX_FREQ, `DPBB_IDX_STAT: begin
                ok = 1'b1;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

endmodule : dpbb_range_check

`default_nettype wire
